/* File: bench/ssd_scan_seq.sv */
// scan sequencer model: channel beats closed by the status word
`timescale 1ns/1ps
`default_nettype none
module ssd_scan_seq
  import ssd_pkg::*;
(
  input  wire logic              i_clk,
  output var  ssd_pkg::ssd_scan_t o_scan
);
  localparam logic [7:0] STAT_CH = 8'hf0;  // status word channel id
  initial o_scan = '0;
  // one beat; released fields show the inverse afterwards
  task automatic beat(input logic [7:0] ch, input logic [15:0] w, input logic lst);
    @(posedge i_clk);
    o_scan <= '{valid: 1'b1, last: lst, chan: ch, data: w};
    @(posedge i_clk);
    o_scan <= '{valid: 1'b0, last: 1'b0, chan: ~ch, data: ~w};
  endtask
  // scan of one channel
  task automatic scan1(input logic [7:0] ch, input logic [15:0] w);
    beat(ch, w, 1'b0);
    beat(STAT_CH, 16'h0000, 1'b1);
  endtask
  // scan of channels 1..n holding one word
  task automatic scan_all(input logic [15:0] w, input int n);
    for (int c = 1; c <= n; c++)
      beat(8'(c), w, 1'b0);
    beat(STAT_CH, 16'h0000, 1'b1);
  endtask
endmodule
`default_nettype wire

/* File: bench/ssd_setpoint_detect_bench.sv */
// self-checking bench for the scan setpoint detect block
`timescale 1ns/1ps
`default_nettype none
module ssd_setpoint_detect_bench;
  import ssd_pkg::*;
  localparam int LIMIT = 20000;  // cycle ceiling of the run
  logic         clk;
  logic         srst;
  logic         ce;
  logic         acq;
  ssd_scan_t    scan;
  ssd_axi_req_t req;
  ssd_axi_rsp_t rsp;
  ssd_out_t     out;
  int           failures = 0;
  int           cmp_count = 0;
  int           cyc = 0;
  int           n;
  logic [15:0]  port_e;
  logic [31:0]  rdv;
  logic [1:0]   rr;
  logic [11:0]  roff [7] = '{SSD_OFF_STAT, SSD_OFF_PORT, SSD_OFF_DAC0, SSD_OFF_DAC1,
                           SSD_OFF_TMR0, SSD_OFF_TMR1, SSD_OFF_SP};
  logic [15:0]  wl [5] = '{16'd49, 16'd50, 16'd75, 16'd100, 16'd101};
  logic [15:0]  hw [5] = '{16'd40, 16'd75, 16'd120, 16'd75, 16'd40};
  logic         hf [5] = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b1};

  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  ssd_setpoint_detect uut (.i_clk(clk), .i_srst(srst), .i_ce(ce), .i_acq_run(acq),
    .i_scan(scan), .i_axi(req), .o_axi(rsp), .o_out(out));
  ssd_scan_seq seq (.i_clk(clk), .o_scan(scan));

  task automatic check(input string what, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e)
    begin
      failures++;
      $display("FAIL %s expected %h seen %h", what, e, g);
    end
  endtask
  // write: address and data offered together, each dropped when taken
  task automatic wr(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
    req.bready  <= 1'b0;
    req.awaddr  <= a;
    req.wdata   <= d;
    req.wstrb   <= 4'hf;
    req.awvalid <= 1'b1;
    req.wvalid  <= 1'b1;
    do
    begin
      @(posedge clk);
      if (req.awvalid && rsp.awready) req.awvalid <= 1'b0;
      if (req.wvalid && rsp.wready) req.wvalid <= 1'b0;
    end
    while (!rsp.bvalid);
    req.bready <= 1'b1;  // response left standing one cycle
    @(posedge clk);
    r = rsp.bresp;
  endtask
  task automatic wr_ok(input logic [11:0] a, input logic [31:0] d);
    wr(a, d, rr);
    check("bresp", SSD_OKAY, rr);
  endtask
  task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
    req.rready  <= 1'b0;
    req.araddr  <= a;
    req.arvalid <= 1'b1;
    do
    begin
      @(posedge clk);
      if (req.arvalid && rsp.arready) req.arvalid <= 1'b0;
    end
    while (!rsp.rvalid);
    req.rready <= 1'b1;  // read data left standing one cycle
    @(posedge clk);
    d = rsp.rdata;
    r = rsp.rresp;
  endtask
  // setpoint k with upper 100 and lower 50
  task automatic sp(input int k, input logic [7:0] ch, input logic [2:0] cr,
                    input logic [2:0] tg, input logic bo, input logic [15:0] o1,
                    input logic [15:0] o2);
    logic [11:0] b;
    b = SSD_OFF_SP + 12'(k * 32);
    wr_ok(b + 12'h004, 32'd100);
    wr_ok(b + 12'h008, 32'd50);
    wr_ok(b + 12'h00c, {16'h0000, o1});
    wr_ok(b + 12'h010, {16'h0000, o2});
    wr_ok(b, {1'b1, 14'h0, bo, 1'b0, tg, 1'b0, cr, ch});
  endtask
  task automatic wait_tog(input int k, output int m);
    logic v;
    v = out.timer[k];
    m = 0;
    do
    begin
      @(posedge clk);
      m++;
    end
    while (out.timer[k] === v);
  endtask
  function automatic logic hit(input int c, input logic [15:0] w);
    case (c)
      0: return w == 16'd100;
      1: return w < 16'd100;
      2: return w > 16'd50;
      3: return w > 16'd50 && w < 16'd100;
      default: return w < 16'd50 || w > 16'd100;
    endcase
  endfunction
  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // hang guard
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == LIMIT)
    begin
      failures++;
      tally_and_finish();
    end
  end

  initial
  begin
    srst = 1'b1;
    ce   = 1'b1;
    acq  = 1'b0;
    req  = '0;
    req.bready = 1'b1;
    req.rready = 1'b1;
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    foreach (roff[i])
    begin
      rd(roff[i], rdv, rr);
      check("reset word", 32'h0, rdv);
    end
    wr_ok(SSD_OFF_STAT, 32'hffff);
    rd(SSD_OFF_STAT, rdv, rr);
    check("status read only", 32'h0, rdv);
    rd(12'h100, rdv, rr);
    check("unmapped rresp", SSD_SLVERR, rr);
    wr(12'h214, 32'h1, rr);
    check("unmapped bresp", SSD_SLVERR, rr);
    $display("test registers done");
    acq <= 1'b1;
    sp(0, 8'd1, 3'd0, 3'd1, 1'b0, 16'h0070, 16'h0000);
    sp(1, 8'd2, 3'd1, 3'd2, 1'b1, 16'h0011, 16'h0022);
    sp(2, 8'd3, 3'd2, 3'd0, 1'b1, 16'h0000, 16'h0000);
    sp(3, 8'd4, 3'd3, 3'd3, 1'b1, 16'h0033, 16'h0044);
    sp(4, 8'd5, 3'd4, 3'd0, 1'b0, 16'h0000, 16'h0000);
    port_e = 16'h0000;
    foreach (wl[i])
    begin
      seq.scan_all(wl[i], 5);
      @(posedge clk);
      for (int c = 0; c < 5; c++)
        check("flag", 32'(hit(c, wl[i])), 32'(out.flags[c]));
      if (hit(0, wl[i])) port_e = 16'h0070;
      check("port", port_e, out.port);
      check("dac0", hit(1, wl[i]) ? 16'h0011 : 16'h0022, out.dac0);
      check("dac1", hit(3, wl[i]) ? 16'h0033 : 16'h0044, out.dac1);
    end
    rd(SSD_OFF_STAT, rdv, rr);
    check("status", 32'h14, rdv);
    $display("test criteria done");
    sp(5, 8'd6, 3'd5, 3'd1, 1'b0, 16'h0001, 16'h0002);
    foreach (hw[i])
    begin
      seq.scan1(8'd6, hw[i]);
      @(posedge clk);
      check("hyst flag", 32'(hf[i]), 32'(out.flags[5]));
      check("hyst port", hf[i] ? 32'h1 : 32'h2, out.port);
    end
    $display("test hysteresis done");
    seq.beat(8'd1, 16'd100, 1'b0);
    seq.beat(8'd1, 16'd49, 1'b0);
    seq.beat(8'hf0, 16'h0000, 1'b1);
    @(posedge clk);
    check("once per scan", 32'h1, 32'(out.flags[0]));
    ce <= 1'b0;
    seq.scan1(8'd1, 16'd49);
    ce <= 1'b1;
    check("frozen", 32'h1, 32'(out.flags[0]));
    acq <= 1'b0;
    seq.scan1(8'd1, 16'd49);
    @(posedge clk);
    check("idle", 32'h1, 32'(out.flags[0]));
    acq <= 1'b1;
    seq.scan1(8'd1, 16'd49);
    @(posedge clk);
    check("rearmed", 32'h0, 32'(out.flags[0]));
    $display("test cadence done");
    wr_ok(SSD_OFF_TMR0, 32'h2);
    wait_tog(0, n);
    wait_tog(0, n);
    check("half period", 32'd250, 32'(n));
    wr_ok(SSD_OFF_TMR1, 32'hffff);
    rd(SSD_OFF_TMR1, rdv, rr);
    check("host ffff runs", 32'h1ffff, rdv);
    sp(6, 8'd7, 3'd0, 3'd5, 1'b0, 16'hffff, 16'h0000);
    seq.scan1(8'd7, 16'd100);
    @(posedge clk);
    rd(SSD_OFF_TMR1, rdv, rr);
    check("setpoint ffff stops", 32'hffff, rdv);
    check("timer1 low", 32'h0, 32'(out.timer[1]));
    rd(SSD_OFF_TMR0, rdv, rr);
    check("timer0 kept", 32'h10002, rdv);
    sp(7, 8'd8, 3'd0, 3'd4, 1'b0, 16'h0003, 16'h0000);
    seq.scan1(8'd8, 16'd100);
    rd(SSD_OFF_TMR0, rdv, rr);
    check("timer0 from setpoint", 32'h10003, rdv);
    $display("test timers done");
    tally_and_finish();
  end
endmodule
`default_nettype wire

/* File: bench/ssd_setpoint_detect_monitor.sv */
// assertion checker on the ports of the scan setpoint detect block
`timescale 1ns/1ps
`default_nettype none
module ssd_setpoint_detect_monitor
  import ssd_pkg::*;
(
  input wire logic                  i_clk,
  input wire logic                  i_srst,
  input wire logic                  i_ce,
  input wire logic                  i_acq_run,
  input wire ssd_pkg::ssd_scan_t    i_scan,
  input wire ssd_pkg::ssd_axi_req_t i_axi,
  input wire ssd_pkg::ssd_axi_rsp_t o_axi,
  input wire ssd_pkg::ssd_out_t     o_out
);
  logic [15:0] gap_reg;
  logic        armed_reg;
  logic        t0_reg;
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_srst);
  // cycles since timer 0 last moved; any load disarms the check
  always_ff @(posedge i_clk)
  begin
    t0_reg <= o_out.timer[0];
    if (i_srst || i_axi.awvalid || i_scan.valid)
    begin
      gap_reg   <= 16'h0000;
      armed_reg <= 1'b0;
    end
    else if (o_out.timer[0] != t0_reg)
    begin
      gap_reg   <= 16'h0000;
      armed_reg <= 1'b1;
    end
    else if (gap_reg != 16'hffff)
      gap_reg <= gap_reg + 16'h0001;
  end
  // port relations over time
  a_reset_clears: assert property (disable iff (1'b0)
    i_srst |=> o_out == '0 && !o_axi.bvalid && !o_axi.rvalid) else $error("reset left state");
  a_freeze_hold: assert property (
    !i_ce |=> $stable(o_out)) else $error("outputs moved with clock enable low");
  a_flag_cadence: assert property (
    !$stable(o_out.flags) |-> $past(i_srst) || $past(i_scan.valid && i_ce && i_acq_run))
    else $error("flags moved without a scan beat");
  a_wr_answer: assert property (
    i_axi.awvalid && o_axi.awready && i_axi.wvalid && o_axi.wready |-> ##1 !o_axi.bvalid
    ##1 o_axi.bvalid) else $error("write answer late");
  a_rd_answer: assert property (
    i_axi.arvalid && o_axi.arready |=> o_axi.rvalid) else $error("read answer late");
  a_bresp_hold: assert property (
    o_axi.bvalid && !i_axi.bready |=> o_axi.bvalid && $stable(o_axi.bresp))
    else $error("write answer dropped");
  a_rresp_hold: assert property (
    o_axi.rvalid && !i_axi.rready |=> o_axi.rvalid && $stable(o_axi.rdata))
    else $error("read answer dropped");
  a_unmapped_rd: assert property (
    i_axi.arvalid && o_axi.arready && i_axi.araddr inside {[12'h018:12'h1fc]}
    |=> o_axi.rresp == SSD_SLVERR && o_axi.rdata == 32'h0) else $error("unmapped read");
  a_stat_match: assert property (
    i_axi.arvalid && o_axi.arready && i_axi.araddr == SSD_OFF_STAT
    |=> o_axi.rdata == {16'h0000, $past(o_out.flags)}) else $error("status word wrong");
  a_timer_gap: assert property (
    o_out.timer[0] != t0_reg && armed_reg |-> gap_reg >= 16'd124)
    else $error("timer toggled too soon");
  // main scenarios reached
  c_scan_end: cover property (i_scan.valid && i_scan.last && i_acq_run);
  c_write_done: cover property (o_axi.bvalid && i_axi.bready);
  c_timer_rise: cover property ($rose(o_out.timer[0]));
endmodule
bind ssd_setpoint_detect ssd_setpoint_detect_monitor u_mon (.i_clk(i_clk), .i_srst(i_srst),
  .i_ce(i_ce), .i_acq_run(i_acq_run), .i_scan(i_scan), .i_axi(i_axi), .o_axi(o_axi),
  .o_out(o_out));
`default_nettype wire

/* File: rtl/ssd_pkg.sv */
// package: register map, field layout, types and timing for scan setpoint detect
package ssd_pkg;
  localparam int          SSD_NSP       = 16;         // setpoints per scan group
  localparam int          SSD_NTMR      = 2;          // square-wave timers
  localparam int          SSD_CLK_MHZ   = 250;        // clock rate
  localparam int          SSD_HALF_NS   = 500;        // half of the 1 us base period
  localparam int          SSD_HALF_CYC  = SSD_HALF_NS * SSD_CLK_MHZ / 1000;
  localparam logic [15:0] SSD_TMR_OFF   = 16'hffff;   // setpoint divisor that stops a timer
  localparam logic [15:0] SSD_RST_WORD  = 16'h0000;   // reset value of the port and DAC outputs
  // register byte offsets
  localparam logic [11:0] SSD_OFF_STAT  = 12'h000;
  localparam logic [11:0] SSD_OFF_PORT  = 12'h004;
  localparam logic [11:0] SSD_OFF_DAC0  = 12'h008;
  localparam logic [11:0] SSD_OFF_DAC1  = 12'h00c;
  localparam logic [11:0] SSD_OFF_TMR0  = 12'h010;
  localparam logic [11:0] SSD_OFF_TMR1  = 12'h014;
  localparam logic [11:0] SSD_OFF_SP    = 12'h200;    // setpoint n at SP + n*0x20
  localparam logic [2:0]  SSD_SP_CFG    = 3'h0;       // word index within a setpoint
  localparam logic [2:0]  SSD_SP_HI     = 3'h1;
  localparam logic [2:0]  SSD_SP_LO     = 3'h2;
  localparam logic [2:0]  SSD_SP_OUT1   = 3'h3;
  localparam logic [2:0]  SSD_SP_OUT2   = 3'h4;
  // setpoint config word fields
  localparam int          SSD_CFG_CHAN  = 0;          // [7:0] scan channel
  localparam int          SSD_CFG_CRIT  = 8;          // [10:8] criterion
  localparam int          SSD_CFG_TGT   = 12;         // [14:12] target
  localparam int          SSD_CFG_BOTH  = 16;         // update on true and false
  localparam int          SSD_CFG_EN    = 31;         // setpoint in use
  localparam int          SSD_TMR_EN    = 16;         // timer register: running bit
  localparam logic [1:0]  SSD_OKAY      = 2'b00;
  localparam logic [1:0]  SSD_SLVERR    = 2'b10;

  typedef enum logic [2:0] {CRIT_EQ, CRIT_BELOW, CRIT_ABOVE, CRIT_INSIDE, CRIT_OUTSIDE,
                            CRIT_HYST} ssd_crit_t;
  typedef enum logic [2:0] {TGT_NONE, TGT_PORT, TGT_DAC0, TGT_DAC1, TGT_TMR0,
                            TGT_TMR1} ssd_tgt_t;

  typedef struct packed {
    logic        en;
    logic        both;
    ssd_tgt_t    tgt;
    ssd_crit_t   crit;
    logic [7:0]  chan;
  } ssd_cfg_t;

  typedef struct packed {
    ssd_cfg_t    cfg;
    logic [15:0] hi;
    logic [15:0] lo;
    logic [15:0] out1;
    logic [15:0] out2;
  } ssd_sp_t;

  typedef struct packed {
    logic        valid;
    logic        last;
    logic [7:0]  chan;
    logic [15:0] data;
  } ssd_scan_t;

  typedef struct packed {
    logic [15:0] flags;
    logic [15:0] port;
    logic [15:0] dac0;
    logic [15:0] dac1;
    logic [1:0]  timer;
  } ssd_out_t;

  typedef struct packed {
    logic        awvalid;
    logic [11:0] awaddr;
    logic        wvalid;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        bready;
    logic        arvalid;
    logic [11:0] araddr;
    logic        rready;
  } ssd_axi_req_t;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } ssd_axi_rsp_t;

  typedef struct packed {
    logic                       aw_have;
    logic [11:0]                aw_addr;
    logic                       w_have;
    logic [31:0]                w_data;
    logic [3:0]                 w_strb;
    logic                       bvalid;
    logic [1:0]                 bresp;
    logic                       rvalid;
    logic [31:0]                rdata;
    logic [1:0]                 rresp;
    ssd_sp_t [SSD_NSP-1:0]      sp;
    logic [SSD_NSP-1:0]         flags;
    logic [SSD_NSP-1:0]         done;
    logic [15:0]                port;
    logic [15:0]                dac0;
    logic [15:0]                dac1;
    logic [7:0]                 presc;
    logic [SSD_NTMR-1:0][15:0]  tdiv;
    logic [SSD_NTMR-1:0]        ten;
    logic [SSD_NTMR-1:0][15:0]  tcnt;
    logic [SSD_NTMR-1:0]        tout;
  } ssd_state_t;
endpackage

/* File: rtl/ssd_setpoint_detect.sv */
// scan setpoint detection with output targets, two timers and AXI4-Lite registers
//
// The implementer's own choices: register access over AXI4-Lite and the register offsets.
`timescale 1ns/1ps
`default_nettype none

// Contract
// RULE1 - two independent 16-bit divisor square-wave timers
// RULE2 - period equals divisor in microseconds
// RULE3 - 0xffff stops timer from setpoint, runs from host
// RULE4 - host may rewrite divisors at any time
// RULE5 - setpoint outcome loads timers while acquiring
// RULE6 - per-channel flag follows the criterion
// RULE7 - flags are available to the scan group
// RULE8 - compare raw 16-bit word regardless of meaning
// RULE9 - single-point: equal, below upper, above lower
// RULE10 - window inside or outside, strict compares
// RULE11 - true-only mode writes first value
// RULE12 - true-and-false writes first or second value
// RULE13 - hysteresis forces second above, first below
// RULE14 - hysteresis holds flag inside window
// RULE15 - each flag evaluated once per scan
// RULE16 - one setpoint per channel, sixteen total
// RULE17 - counter halves are independent channel words
// RULE18 - upper and lower 16-bit limits per setpoint
// RULE19 - 16-bit output value to port, DAC or timer
// RULE20 - status word bit n is setpoint n
// RULE21 - status word is last scan channel
// RULE22 - target written in the evaluating scan
module ssd_setpoint_detect
  import ssd_pkg::*;
(
  input  wire logic                  i_clk,
  input  wire logic                  i_srst,
  input  wire logic                  i_ce,
  input  wire logic                  i_acq_run,
  input  wire ssd_pkg::ssd_scan_t    i_scan,
  input  wire ssd_pkg::ssd_axi_req_t i_axi,
  output var  ssd_pkg::ssd_axi_rsp_t o_axi,
  output var  ssd_pkg::ssd_out_t     o_out
);
  import ssd_pkg::*;

  ssd_state_t s_reg;
  ssd_state_t s_next;
  logic       aw_hs;
  logic       w_hs;
  logic       ar_hs;

  // byte-lane merge for register writes
  function automatic logic [31:0] merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                        input logic [3:0] strb);
    logic [31:0] r;
    r = old_v;
    for (int b = 0; b < 4; b++)
    begin
      if (strb[b])
      begin
        r[8*b +: 8] = new_v[8*b +: 8];
      end
    end
    return r;
  endfunction

  // criterion test on the raw word, limits compared strictly
  function automatic logic crit_true(input ssd_sp_t p, input logic [15:0] x);
    logic t;
    t = 1'b0;
    case (p.cfg.crit)
      CRIT_EQ:      t = (x == p.hi);                    // RULE9
      CRIT_BELOW:   t = (x < p.hi);                     // RULE9
      CRIT_ABOVE:   t = (x > p.lo);                     // RULE9
      CRIT_INSIDE:  t = (x > p.lo) && (x < p.hi);       // RULE10
      CRIT_OUTSIDE: t = (x < p.lo) || (x > p.hi);       // RULE10
      default:      t = 1'b0;
    endcase
    return t;
  endfunction

  // setpoint register readback
  function automatic logic [31:0] sp_read(input ssd_sp_t p, input logic [2:0] w);
    logic [31:0] r;
    r = 32'h0000_0000;
    if (w == SSD_SP_CFG)
    begin
      r[SSD_CFG_CHAN +: 8] = p.cfg.chan;
      r[SSD_CFG_CRIT +: 3] = p.cfg.crit;
      r[SSD_CFG_TGT +: 3]  = p.cfg.tgt;
      r[SSD_CFG_BOTH]      = p.cfg.both;
      r[SSD_CFG_EN]        = p.cfg.en;
    end
    else if (w == SSD_SP_HI)
    begin
      r[15:0] = p.hi;
    end
    else if (w == SSD_SP_LO)
    begin
      r[15:0] = p.lo;
    end
    else if (w == SSD_SP_OUT1)
    begin
      r[15:0] = p.out1;
    end
    else if (w == SSD_SP_OUT2)
    begin
      r[15:0] = p.out2;
    end
    return r;
  endfunction

  // handshakes; stalled while the clock enable is low
  assign aw_hs = i_axi.awvalid && o_axi.awready;
  assign w_hs  = i_axi.wvalid && o_axi.wready;
  assign ar_hs = i_axi.arvalid && o_axi.arready;

  always_comb
  begin
    o_axi.awready = i_ce && !s_reg.aw_have && !s_reg.bvalid;
    o_axi.wready  = i_ce && !s_reg.w_have && !s_reg.bvalid;
    o_axi.arready = i_ce && !s_reg.rvalid;
    o_axi.bvalid  = s_reg.bvalid;
    o_axi.bresp   = s_reg.bresp;
    o_axi.rvalid  = s_reg.rvalid;
    o_axi.rdata   = s_reg.rdata;
    o_axi.rresp   = s_reg.rresp;
  end

  // outputs straight from state flops
  always_comb
  begin
    o_out.flags = s_reg.flags;          // RULE7 RULE20
    o_out.port  = s_reg.port;
    o_out.dac0  = s_reg.dac0;
    o_out.dac1  = s_reg.dac1;
    o_out.timer = s_reg.tout;
  end

  // next-state: bus, scan evaluation, timers
  always_comb
  begin
    logic [31:0] wv;
    logic [11:0] a;
    logic [3:0]  si;
    logic [2:0]  sw;
    logic        found;
    logic [3:0]  hit;
    logic        res;
    logic        wr;
    logic [15:0] val;
    ssd_sp_t     p;
    wv    = 32'h0000_0000;
    a     = 12'h000;
    si    = 4'h0;
    sw    = 3'h0;
    found = 1'b0;
    hit   = 4'h0;
    res   = 1'b0;
    wr    = 1'b0;
    val   = 16'h0000;
    p     = '0;
    s_next = s_reg;

    // capture write address and data in either order
    if (aw_hs)
    begin
      s_next.aw_have = 1'b1;
      s_next.aw_addr = i_axi.awaddr;
    end
    if (w_hs)
    begin
      s_next.w_have = 1'b1;
      s_next.w_data = i_axi.wdata;
      s_next.w_strb = i_axi.wstrb;
    end
    if (s_reg.bvalid && i_axi.bready)
    begin
      s_next.bvalid = 1'b0;
    end

    // register write once both halves are held
    if (s_reg.aw_have && s_reg.w_have)
    begin
      a  = {s_reg.aw_addr[11:2], 2'b00};
      si = a[8:5];
      sw = a[4:2];
      s_next.aw_have = 1'b0;
      s_next.w_have  = 1'b0;
      s_next.bvalid  = 1'b1;
      s_next.bresp   = SSD_OKAY;
      if (a == SSD_OFF_STAT)
      begin
        s_next.bresp = SSD_OKAY;        // read-only, write ignored
      end
      else if (a == SSD_OFF_PORT)
      begin
        wv = merge({16'h0000, s_reg.port}, s_reg.w_data, s_reg.w_strb);
        s_next.port = wv[15:0];
      end
      else if (a == SSD_OFF_DAC0)
      begin
        wv = merge({16'h0000, s_reg.dac0}, s_reg.w_data, s_reg.w_strb);
        s_next.dac0 = wv[15:0];
      end
      else if (a == SSD_OFF_DAC1)
      begin
        wv = merge({16'h0000, s_reg.dac1}, s_reg.w_data, s_reg.w_strb);
        s_next.dac1 = wv[15:0];
      end
      else if (a == SSD_OFF_TMR0 || a == SSD_OFF_TMR1)
      begin
        // host divisor: taken any time, 0xffff still runs
        wv = merge({16'h0000, s_reg.tdiv[a[2]]}, s_reg.w_data, s_reg.w_strb);
        s_next.tdiv[a[2]] = wv[15:0];   // RULE4
        s_next.ten[a[2]]  = 1'b1;       // RULE3
        s_next.tcnt[a[2]] = 16'h0000;
      end
      else if (a >= SSD_OFF_SP && a < SSD_OFF_SP + 12'h200 && sw <= SSD_SP_OUT2)
      begin
        wv = merge(sp_read(s_reg.sp[si], sw), s_reg.w_data, s_reg.w_strb);
        if (sw == SSD_SP_CFG)
        begin
          s_next.sp[si].cfg.chan = wv[SSD_CFG_CHAN +: 8];
          s_next.sp[si].cfg.crit = ssd_crit_t'(wv[SSD_CFG_CRIT +: 3]);
          s_next.sp[si].cfg.tgt  = ssd_tgt_t'(wv[SSD_CFG_TGT +: 3]);
          s_next.sp[si].cfg.both = wv[SSD_CFG_BOTH];
          s_next.sp[si].cfg.en   = wv[SSD_CFG_EN];
        end
        else if (sw == SSD_SP_HI)
        begin
          s_next.sp[si].hi = wv[15:0];  // RULE18
        end
        else if (sw == SSD_SP_LO)
        begin
          s_next.sp[si].lo = wv[15:0];  // RULE18
        end
        else if (sw == SSD_SP_OUT1)
        begin
          s_next.sp[si].out1 = wv[15:0];
        end
        else
        begin
          s_next.sp[si].out2 = wv[15:0];
        end
      end
      else
      begin
        s_next.bresp = SSD_SLVERR;
      end
    end

    // register read, answered one cycle after the address
    if (s_reg.rvalid && i_axi.rready)
    begin
      s_next.rvalid = 1'b0;
    end
    if (ar_hs)
    begin
      a  = {i_axi.araddr[11:2], 2'b00};
      si = a[8:5];
      sw = a[4:2];
      s_next.rvalid = 1'b1;
      s_next.rresp  = SSD_OKAY;
      s_next.rdata  = 32'h0000_0000;
      if (a == SSD_OFF_STAT)
      begin
        s_next.rdata[15:0] = s_reg.flags;   // RULE20
      end
      else if (a == SSD_OFF_PORT)
      begin
        s_next.rdata[15:0] = s_reg.port;
      end
      else if (a == SSD_OFF_DAC0)
      begin
        s_next.rdata[15:0] = s_reg.dac0;
      end
      else if (a == SSD_OFF_DAC1)
      begin
        s_next.rdata[15:0] = s_reg.dac1;
      end
      else if (a == SSD_OFF_TMR0 || a == SSD_OFF_TMR1)
      begin
        s_next.rdata[15:0]       = s_reg.tdiv[a[2]];
        s_next.rdata[SSD_TMR_EN] = s_reg.ten[a[2]];
      end
      else if (a >= SSD_OFF_SP && a < SSD_OFF_SP + 12'h200 && sw <= SSD_SP_OUT2)
      begin
        s_next.rdata = sp_read(s_reg.sp[si], sw);
      end
      else
      begin
        s_next.rresp = SSD_SLVERR;
      end
    end

    // find the setpoint of this word; lowest index owns the channel
    for (int i = SSD_NSP - 1; i >= 0; i--)
    begin
      if (s_reg.sp[i].cfg.en && s_reg.sp[i].cfg.chan == i_scan.chan)  // RULE16 RULE17
      begin
        found = 1'b1;
        hit   = 4'(i);
      end
    end

    // evaluate at most once per scan while acquiring
    if (i_scan.valid && i_acq_run && found && !s_reg.done[hit])  // RULE15
    begin
      p = s_reg.sp[hit];
      s_next.done[hit] = 1'b1;                                     // RULE15
      if (p.cfg.crit == CRIT_HYST)
      begin
        // above upper -> second value, below lower -> first value
        if (i_scan.data > p.hi)
        begin
          s_next.flags[hit] = 1'b0;     // RULE13
          wr  = 1'b1;
          val = p.out2;                 // RULE13
        end
        else if (i_scan.data < p.lo)
        begin
          s_next.flags[hit] = 1'b1;     // RULE13
          wr  = 1'b1;
          val = p.out1;                 // RULE13
        end
        // inside the window the flag and target stay put; RULE14
      end
      else
      begin
        res = crit_true(p, i_scan.data);  // RULE8
        s_next.flags[hit] = res;          // RULE6
        wr  = res || p.cfg.both;          // RULE11 RULE12
        val = res ? p.out1 : p.out2;      // RULE12
      end
      // target update in the same cycle as the compare
      if (wr)                             // RULE22 RULE19
      begin
        case (p.cfg.tgt)
          TGT_PORT: s_next.port = val;
          TGT_DAC0: s_next.dac0 = val;
          TGT_DAC1: s_next.dac1 = val;
          TGT_TMR0, TGT_TMR1:
          begin
            s_next.tdiv[p.cfg.tgt == TGT_TMR1] = val;                     // RULE5
            s_next.ten[p.cfg.tgt == TGT_TMR1]  = (val != SSD_TMR_OFF);    // RULE3
            s_next.tcnt[p.cfg.tgt == TGT_TMR1] = 16'h0000;
          end
          default: s_next.port = s_next.port;
        endcase
      end
    end

    // the end of a scan re-arms every setpoint
    if (i_scan.valid && i_scan.last)
    begin
      s_next.done = '0;                 // RULE15
    end
    if (!i_acq_run)
    begin
      s_next.done = '0;
    end

    // half-microsecond prescaler shared by both timers
    if (s_reg.presc == 8'(SSD_HALF_CYC - 1))
    begin
      s_next.presc = 8'h00;
    end
    else
    begin
      s_next.presc = s_reg.presc + 8'h01;
    end

    // each timer toggles every divisor half-periods
    for (int k = 0; k < SSD_NTMR; k++)
    begin
      if (!s_reg.ten[k])
      begin
        s_next.tout[k] = 1'b0;          // RULE3
        s_next.tcnt[k] = 16'h0000;
      end
      else if (s_reg.presc == 8'(SSD_HALF_CYC - 1) && s_next.tcnt[k] == s_reg.tcnt[k])
      begin
        if (s_reg.tcnt[k] == s_reg.tdiv[k] - 16'h0001)   // RULE1 RULE2
        begin
          s_next.tcnt[k] = 16'h0000;
          s_next.tout[k] = !s_reg.tout[k];
        end
        else
        begin
          s_next.tcnt[k] = s_reg.tcnt[k] + 16'h0001;
        end
      end
    end
  end

  // state register, frozen while the clock enable is low unless reset is high
  always_ff @(posedge i_clk)
  begin
    if (i_srst)
    begin
      s_reg      <= '0;
      s_reg.port <= SSD_RST_WORD;
      s_reg.dac0 <= SSD_RST_WORD;
      s_reg.dac1 <= SSD_RST_WORD;
    end
    else if (i_ce)
    begin
      s_reg <= s_next;
    end
  end
endmodule

`default_nettype wire
